// >>> rtl/mem_map_pkg.sv
// constants, types and map tables for the memory map decoder
package mem_map_pkg;

  // address spaces seen on each bus
  localparam int        ADDR_W         = 16;
  localparam logic [1:0] SPACE_PROG    = 2'h0;
  localparam logic [1:0] SPACE_LOCAL   = 2'h1;
  localparam logic [1:0] SPACE_GLOBAL  = 2'h2;
  localparam logic [1:0] SPACE_IO      = 2'h3;

  // device variants
  localparam logic [1:0] VAR_BOOT      = 2'h0;
  localparam logic [1:0] VAR_ROM8K     = 2'h1;
  localparam logic [1:0] VAR_ROM16K    = 2'h2;

  // program space bounds per variant
  localparam logic [15:0] V0_ROM_TOP   = 16'h07FF;
  localparam logic [15:0] V0_PSA_LO    = 16'h0800;
  localparam logic [15:0] V0_PSA_HI    = 16'h2BFF;
  localparam logic [15:0] V1_ROM_TOP   = 16'h1FFF;
  localparam logic [15:0] V1_PSA_LO    = 16'h2000;
  localparam logic [15:0] V1_PSA_HI    = 16'h23FF;
  localparam logic [15:0] V2_ROM_TOP   = 16'h3FFF;
  localparam logic [15:0] V2_PSA_LO    = 16'h4000;
  localparam logic [15:0] V2_PSA_HI    = 16'h4BFF;
  localparam logic [15:0] PB0_LO       = 16'hFE00;

  // local data space bounds and the start of global space
  localparam logic [15:0] MMR_HI       = 16'h005F;
  localparam logic [15:0] B2_LO        = 16'h0060;
  localparam logic [15:0] B2_HI        = 16'h007F;
  localparam logic [15:0] DB0_LO       = 16'h0100;
  localparam logic [15:0] DB0_HI       = 16'h02FF;
  localparam logic [15:0] B1_LO        = 16'h0300;
  localparam logic [15:0] B1_HI        = 16'h04FF;
  localparam logic [15:0] DSA_LO       = 16'h0800;
  localparam logic [15:0] V0_DSA_HI    = 16'h2BFF;
  localparam logic [15:0] V1_DSA_HI    = 16'h0BFF;
  localparam logic [15:0] V2_DSA_HI    = 16'h13FF;
  localparam logic [15:0] GLOBAL_LO    = 16'h8000;

  // register bus
  localparam logic [11:0] CFG_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam int          CFG_MODE_BIT = 0;
  localparam int          CFG_RAM_BIT  = 1;
  localparam int          CFG_B0_BIT   = 2;
  localparam int          CFG_SRAM_DATA_OVERLAY_BIT = 3;
  localparam int          ST_VAR_LSB   = 0;
  localparam int          ST_PIN_BIT   = 2;
  localparam int          ST_CONF_BIT  = 3;
  localparam logic        RST_RAM      = 1'b0;
  localparam logic        RST_B0       = 1'b0;
  localparam logic        RST_SRAM_DATA_OVERLAY     = 1'b0;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

  // where an access is steered
  typedef enum logic [3:0] {
    TGT_NONE,
    TGT_MMR,
    TGT_ROM,
    TGT_SINGLE_ACCESS_RAM,
    TGT_B0,
    TGT_B1,
    TGT_B2,
    TGT_EXT,
    TGT_RSVD
  } target_t;

endpackage : mem_map_pkg

// >>> rtl/mem_map_decoder.sv
// memory map decoder with three address buses and an apb configuration port
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps

module mem_map_decoder
  import mem_map_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_BOOT
) (
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SRST,
  // mode strap pin
  input  wire logic        I_PROCESSOR_MODE_SELECT,
  // program address bus
  input  wire logic        I_PROG_REQ,
  input  wire logic        I_PROG_WR,
  input  wire logic [15:0] I_PROG_ADDR,
  // data read address bus
  input  wire logic        I_DRD_REQ,
  input  wire logic [1:0]  I_DRD_SPACE,
  input  wire logic [15:0] I_DRD_ADDR,
  // data write address bus
  input  wire logic        I_DWR_REQ,
  input  wire logic [1:0]  I_DWR_SPACE,
  input  wire logic [15:0] I_DWR_ADDR,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // program bus decode
  output logic [3:0]       O_PROG_TGT,
  output logic             O_PROG_EXT,
  output logic             O_PROG_WAIT,
  output logic [15:0]      O_PROG_OFS,
  // data read decode
  output logic [3:0]       O_DRD_TGT,
  output logic             O_DRD_EXT,
  output logic             O_DRD_WAIT,
  output logic [15:0]      O_DRD_OFS,
  // data write decode
  output logic [3:0]       O_DWR_TGT,
  output logic             O_DWR_EXT,
  output logic             O_DWR_WAIT,
  output logic [15:0]      O_DWR_OFS,
  // configuration view
  output logic             O_ROM_MAPPED
);

  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_strap;
    logic        mode;
    logic        ram_map;
    logic        b0_map;
    logic        sram_data_overlay;
    logic        conflict;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    target_t     p_tgt;
    logic        p_wait;
    logic [15:0] p_ofs;
    target_t     r_tgt;
    logic        r_wait;
    logic [15:0] r_ofs;
    target_t     w_tgt;
    logic        w_wait;
    logic [15:0] w_ofs;
    logic        p_ext;
    logic        r_ext;
    logic        w_ext;
    logic        rom_on;
  } state_t;

  state_t s_q;
  state_t s_d;

  // per-variant bounds
  function automatic logic [15:0] rom_top(input logic [1:0] v);
    case (v)
      VAR_ROM8K:  rom_top = V1_ROM_TOP;
      VAR_ROM16K: rom_top = V2_ROM_TOP;
      default:    rom_top = V0_ROM_TOP;
    endcase
  endfunction : rom_top

  function automatic logic [15:0] psa_lo(input logic [1:0] v);
    case (v)
      VAR_ROM8K:  psa_lo = V1_PSA_LO;
      VAR_ROM16K: psa_lo = V2_PSA_LO;
      default:    psa_lo = V0_PSA_LO;
    endcase
  endfunction : psa_lo

  function automatic logic [15:0] psa_hi(input logic [1:0] v);
    case (v)
      VAR_ROM8K:  psa_hi = V1_PSA_HI;
      VAR_ROM16K: psa_hi = V2_PSA_HI;
      default:    psa_hi = V0_PSA_HI;
    endcase
  endfunction : psa_hi

  function automatic logic [15:0] dsa_hi(input logic [1:0] v);
    case (v)
      VAR_ROM8K:  dsa_hi = V1_DSA_HI;
      VAR_ROM16K: dsa_hi = V2_DSA_HI;
      default:    dsa_hi = V0_DSA_HI;
    endcase
  endfunction : dsa_hi

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // program space steering
  function automatic target_t prog_decode(input logic [15:0] a, input logic wr,
                                          input logic mode, input logic ram,
                                          input logic block_zero_program_map);
    prog_decode = TGT_EXT;
    if (!mode && a <= rom_top(VARIANT)) begin
      // rom cannot take a write; drop it rather than leak it off-chip
      prog_decode = wr ? TGT_RSVD : TGT_ROM;
    end else if (ram && in_rng(a, psa_lo(VARIANT), psa_hi(VARIANT))) begin
      prog_decode = TGT_SINGLE_ACCESS_RAM;
    end else if (block_zero_program_map && a >= PB0_LO) begin
      prog_decode = TGT_B0;
    end
  endfunction : prog_decode

  // data, global and io space steering
  function automatic target_t data_decode(input logic [1:0] sp, input logic [15:0] a,
                                          input logic block_zero_program_map, input logic sram_data_overlay);
    data_decode = TGT_EXT;
    case (sp)
      SPACE_LOCAL: begin
        if (a <= MMR_HI) begin
          data_decode = TGT_MMR;
        end else if (in_rng(a, B2_LO, B2_HI)) begin
          data_decode = TGT_B2;
        end else if (in_rng(a, DB0_LO, DB0_HI)) begin
          data_decode = block_zero_program_map ? TGT_RSVD : TGT_B0;
        end else if (in_rng(a, B1_LO, B1_HI)) begin
          data_decode = TGT_B1;
        end else if (a < DSA_LO) begin
          data_decode = TGT_RSVD;
        end else if (a <= dsa_hi(VARIANT)) begin
          if (sram_data_overlay) begin
            data_decode = TGT_SINGLE_ACCESS_RAM;
          end else begin
            data_decode = (VARIANT == VAR_ROM8K) ? TGT_EXT : TGT_RSVD;
          end
        end
      end
      SPACE_GLOBAL: begin
        // global space is the upper 32K window only
        data_decode = a[15] ? TGT_EXT : TGT_RSVD;
      end
      SPACE_IO: data_decode = TGT_EXT;
      default:  data_decode = TGT_RSVD;
    endcase
  endfunction : data_decode

  // word offset inside the selected block
  function automatic logic [15:0] block_ofs(input target_t t, input logic [15:0] a,
                                            input logic prog);
    case (t)
      TGT_SINGLE_ACCESS_RAM: block_ofs = a - (prog ? psa_lo(VARIANT) : DSA_LO);
      TGT_B0:    block_ofs = a - (prog ? PB0_LO : DB0_LO);
      TGT_B1:    block_ofs = a - B1_LO;
      TGT_B2:    block_ofs = a - B2_LO;
      default:   block_ofs = a;
    endcase
  endfunction : block_ofs

  function automatic logic is_dual(input target_t t);
    is_dual = (t == TGT_B0) || (t == TGT_B1) || (t == TGT_B2);
  endfunction : is_dual

  target_t p_t;
  target_t r_t;
  target_t w_t;
  logic    p_rd;
  logic    p_wr;
  logic    r_wait;
  logic    w_wait;
  logic    apb_done;
  logic    addr_ok;

  // arbitration order is fixed: the fetch is never stalled, so a loop
  // running from single-access ram keeps its pace while operands queue.
  // the dual blocks take one read and one write a cycle; only two of a
  // kind on the same block stall the data bus.
  // every decode result and strobe is a flop, one cycle after the request;
  // this costs a cycle of latency but keeps glitches off the external bus.

  always_comb begin
    s_d = s_q;

    // strap synchroniser; second stage is the only reader of the first
    s_d.pin_s1 = I_PROCESSOR_MODE_SELECT;
    s_d.pin_s2 = s_q.pin_s1;

    // decode uses the mapping held now, so a write lands on later accesses
    p_t = I_PROG_REQ ? prog_decode(I_PROG_ADDR, I_PROG_WR, s_q.mode, s_q.ram_map,
                                   s_q.b0_map) : TGT_NONE;
    r_t = I_DRD_REQ ? data_decode(I_DRD_SPACE, I_DRD_ADDR, s_q.b0_map, s_q.sram_data_overlay)
                    : TGT_NONE;
    w_t = I_DWR_REQ ? data_decode(I_DWR_SPACE, I_DWR_ADDR, s_q.b0_map, s_q.sram_data_overlay)
                    : TGT_NONE;

    p_rd = (p_t != TGT_NONE) && !I_PROG_WR;
    p_wr = (p_t != TGT_NONE) && I_PROG_WR;

    // single-access ram serves one bus; program wins, then read, then write
    r_wait = (r_t == TGT_SINGLE_ACCESS_RAM) && (p_t == TGT_SINGLE_ACCESS_RAM);
    w_wait = (w_t == TGT_SINGLE_ACCESS_RAM) && ((p_t == TGT_SINGLE_ACCESS_RAM) || (r_t == TGT_SINGLE_ACCESS_RAM));
    // dual-access block: one read and one write, never two of a kind
    r_wait = r_wait || (is_dual(r_t) && p_rd && (r_t == p_t));
    w_wait = w_wait || (is_dual(w_t) && p_wr && (w_t == p_t));

    s_d.p_tgt  = p_t;
    s_d.p_wait = 1'b0;
    s_d.p_ofs  = block_ofs(p_t, I_PROG_ADDR, 1'b1);
    s_d.r_tgt  = r_t;
    s_d.r_wait = r_wait;
    s_d.r_ofs  = block_ofs(r_t, I_DRD_ADDR, 1'b0);
    s_d.w_tgt  = w_t;
    s_d.w_wait = w_wait;
    s_d.w_ofs  = block_ofs(w_t, I_DWR_ADDR, 1'b0);
    // strobes registered with the target, never decoded after the flop
    s_d.p_ext  = (p_t == TGT_EXT);
    s_d.r_ext  = (r_t == TGT_EXT);
    s_d.w_ext  = (w_t == TGT_EXT);
    // sticky until software clears; a new conflict beats the clear
    if (r_wait || w_wait) begin
      s_d.conflict = 1'b1;
    end

    // apb: answer one cycle into the access phase, from a flop
    addr_ok  = (I_PADDR == CFG_OFS) || (I_PADDR == STATUS_OFS);
    apb_done = I_PSEL && I_PENABLE && s_q.ready;
    s_d.ready = I_PSEL && I_PENABLE && !s_q.ready;
    if (s_d.ready) begin
      s_d.slverr = !addr_ok;
      s_d.rdata  = ZERO_WORD;
      if (!I_PWRITE && I_PADDR == CFG_OFS) begin
        s_d.rdata[CFG_MODE_BIT] = s_q.mode;
        s_d.rdata[CFG_RAM_BIT]  = s_q.ram_map;
        s_d.rdata[CFG_B0_BIT]   = s_q.b0_map;
        s_d.rdata[CFG_SRAM_DATA_OVERLAY_BIT] = s_q.sram_data_overlay;
      end else if (!I_PWRITE && I_PADDR == STATUS_OFS) begin
        s_d.rdata[ST_VAR_LSB +: 2] = VARIANT;
        s_d.rdata[ST_PIN_BIT]      = s_q.pin_strap;
        s_d.rdata[ST_CONF_BIT]     = s_q.conflict;
      end
    end else if (apb_done) begin
      s_d.slverr = 1'b0;
      s_d.rdata  = ZERO_WORD;
    end
    if (apb_done && I_PWRITE) begin
      if (I_PADDR == CFG_OFS) begin
        s_d.mode    = I_PWDATA[CFG_MODE_BIT];
        s_d.rom_on  = !I_PWDATA[CFG_MODE_BIT];
        s_d.ram_map = I_PWDATA[CFG_RAM_BIT];
        s_d.b0_map  = I_PWDATA[CFG_B0_BIT];
        s_d.sram_data_overlay    = I_PWDATA[CFG_SRAM_DATA_OVERLAY_BIT];
      end else if (I_PADDR == STATUS_OFS && I_PWDATA[ST_CONF_BIT]) begin
        s_d.conflict = r_wait || w_wait;
      end
    end

    if (I_SRST) begin
      s_d           = '0;
      s_d.pin_s1    = I_PROCESSOR_MODE_SELECT;
      s_d.pin_s2    = s_q.pin_s1;
      // strap follows the pin only while reset is held
      s_d.pin_strap = s_q.pin_s2;
      s_d.mode      = s_q.pin_s2;
      s_d.rom_on    = !s_q.pin_s2;
      s_d.ram_map   = RST_RAM;
      s_d.b0_map    = RST_B0;
      s_d.sram_data_overlay      = RST_SRAM_DATA_OVERLAY;
      s_d.p_tgt     = TGT_NONE;
      s_d.r_tgt     = TGT_NONE;
      s_d.w_tgt     = TGT_NONE;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    s_q <= s_d;
  end

  assign O_PRDATA     = s_q.rdata;
  assign O_PREADY     = s_q.ready;
  assign O_PSLVERR    = s_q.slverr;
  assign O_PROG_TGT   = s_q.p_tgt;
  assign O_PROG_EXT   = s_q.p_ext;
  assign O_PROG_WAIT  = s_q.p_wait;
  assign O_PROG_OFS   = s_q.p_ofs;
  assign O_DRD_TGT    = s_q.r_tgt;
  assign O_DRD_EXT    = s_q.r_ext;
  assign O_DRD_WAIT   = s_q.r_wait;
  assign O_DRD_OFS    = s_q.r_ofs;
  assign O_DWR_TGT    = s_q.w_tgt;
  assign O_DWR_EXT    = s_q.w_ext;
  assign O_DWR_WAIT   = s_q.w_wait;
  assign O_DWR_OFS    = s_q.w_ofs;
  assign O_ROM_MAPPED = s_q.rom_on;

endmodule : mem_map_decoder

// >>> dv/mem_map_decoder_asserts.sv
// port-level assertions for the memory map decoder
`timescale 1ns/1ps
module mem_map_decoder_asserts (
  // clock and reset
  input wire logic        I_SYS_CLK,
  input wire logic        I_SRST,
  // address buses
  input wire logic        I_PROG_REQ,
  input wire logic        I_PROG_WR,
  input wire logic [15:0] I_PROG_ADDR,
  input wire logic        I_DRD_REQ,
  input wire logic [1:0]  I_DRD_SPACE,
  input wire logic [15:0] I_DRD_ADDR,
  input wire logic        I_DWR_REQ,
  input wire logic [1:0]  I_DWR_SPACE,
  // apb
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        O_PREADY,
  // decode results
  input wire logic [3:0]  O_PROG_TGT,
  input wire logic        O_PROG_EXT,
  input wire logic        O_PROG_WAIT,
  input wire logic [3:0]  O_DRD_TGT,
  input wire logic        O_DWR_EXT,
  input wire logic        O_DWR_WAIT,
  input wire logic        O_ROM_MAPPED
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);

  a_prog_no_wait: assert property (!O_PROG_WAIT)
    else $error("program bus stalled");
  a_ext_strobe_tgt: assert property (O_PROG_EXT == (O_PROG_TGT == 4'h7))
    else $error("external strobe disagrees with target");
  a_idle_no_tgt: assert property (!I_PROG_REQ |=> O_PROG_TGT == 4'h0)
    else $error("target without request");
  a_mmr_low_data: assert property (I_DRD_REQ && I_DRD_SPACE == 2'h1
    && I_DRD_ADDR <= 16'h005F |=> O_DRD_TGT == 4'h1)
    else $error("register range misdecoded");
  a_block_one_data: assert property (I_DRD_REQ && I_DRD_SPACE == 2'h1
    && I_DRD_ADDR inside {[16'h0300:16'h04FF]} |=> O_DRD_TGT == 4'h5)
    else $error("block one misdecoded");
  a_global_low_rsvd: assert property (I_DRD_REQ && I_DRD_SPACE == 2'h2
    && I_DRD_ADDR < 16'h8000 |=> O_DRD_TGT == 4'h8)
    else $error("global space below 8000h not reserved");
  a_io_goes_ext: assert property (I_DWR_REQ && I_DWR_SPACE == 2'h3
    |=> O_DWR_EXT && !O_DWR_WAIT)
    else $error("io write not external");
  a_reset_vector: assert property (I_PROG_REQ && !I_PROG_WR && I_PROG_ADDR == 16'h0000
    |=> O_PROG_TGT == ($past(O_ROM_MAPPED) ? 4'h2 : 4'h7))
    else $error("reset vector fetch misdirected");
  a_pready_one_wait: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("apb ready late");
  a_pready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("apb ready longer than one cycle");

  c_sram_prog: cover property (O_PROG_TGT == 4'h3);
  c_b0_prog: cover property (O_PROG_TGT == 4'h4);
  c_dwr_wait: cover property (O_DWR_WAIT);
  c_apb_done: cover property (O_PREADY && I_PSEL);
endmodule : mem_map_decoder_asserts

bind mem_map_decoder mem_map_decoder_asserts u_mem_map_decoder_asserts (
  .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_PROG_REQ(I_PROG_REQ),
  .I_PROG_WR(I_PROG_WR), .I_PROG_ADDR(I_PROG_ADDR), .I_DRD_REQ(I_DRD_REQ),
  .I_DRD_SPACE(I_DRD_SPACE), .I_DRD_ADDR(I_DRD_ADDR), .I_DWR_REQ(I_DWR_REQ),
  .I_DWR_SPACE(I_DWR_SPACE), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .O_PREADY(O_PREADY), .O_PROG_TGT(O_PROG_TGT), .O_PROG_EXT(O_PROG_EXT),
  .O_PROG_WAIT(O_PROG_WAIT), .O_DRD_TGT(O_DRD_TGT), .O_DWR_EXT(O_DWR_EXT),
  .O_DWR_WAIT(O_DWR_WAIT), .O_ROM_MAPPED(O_ROM_MAPPED));

// >>> dv/cpu_bus_model.sv
// cpu side: drives the program, data read and data write address buses
`timescale 1ns/1ps
module cpu_bus_model (
  // clock
  input  wire logic  i_clk,
  // buses
  output logic       o_prog_req,
  output logic       o_prog_wr,
  output logic [15:0] o_prog_addr,
  output logic       o_drd_req,
  output logic [1:0] o_drd_space,
  output logic [15:0] o_drd_addr,
  output logic       o_dwr_req,
  output logic [1:0] o_dwr_space,
  output logic [15:0] o_dwr_addr
);
  initial begin
    {o_prog_req, o_prog_wr, o_drd_req, o_dwr_req} = 4'h0;
    {o_prog_addr, o_drd_addr, o_dwr_addr} = 48'h0;
    {o_drd_space, o_dwr_space} = 4'h5;
  end
  // fetch, operand read and operand write in one cycle
  task automatic put(input logic [15:0] pa, input logic [1:0] rs, input logic [15:0] ra,
                     input logic [1:0] ws, input logic [15:0] wa);
    @(posedge i_clk);
    o_prog_req  <= 1'b1;
    o_prog_addr <= pa;
    o_drd_req   <= 1'b1;
    o_drd_space <= rs;
    o_drd_addr  <= ra;
    o_dwr_req   <= 1'b1;
    o_dwr_space <= ws;
    o_dwr_addr  <= wa;
  endtask : put
  // released address lines do not keep the last value
  task automatic idle;
    @(posedge i_clk);
    {o_prog_req, o_drd_req, o_dwr_req} <= 3'h0;
    o_prog_addr <= ~o_prog_addr;
    o_drd_addr  <= ~o_drd_addr;
    o_dwr_addr  <= ~o_dwr_addr;
  endtask : idle
endmodule : cpu_bus_model

// >>> dv/mem_map_decoder_tb.sv
// self-checking testbench for the memory map decoder, second variant
`timescale 1ns/1ps
module mem_map_decoder_tb;
  import mem_map_pkg::*;
  logic clk, srst, strap, psel, penable, pwrite, pready, pslverr, rom_mapped;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic prq, pwr, rrq, wrq, e, mode, ram, block_zero_program_map, sram_data_overlay;
  logic [1:0] rsp, wsp;
  logic [15:0] pa, ra, wa, pofs;
  logic [3:0] ptgt, rtgt, wtgt;
  logic rwait, wwait, pext, rext, wext;
  int failures, total_checks;

  cpu_bus_model u_cpu_bus_model (.i_clk(clk), .o_prog_req(prq), .o_prog_wr(pwr),
    .o_prog_addr(pa), .o_drd_req(rrq), .o_drd_space(rsp), .o_drd_addr(ra),
    .o_dwr_req(wrq), .o_dwr_space(wsp), .o_dwr_addr(wa));
  mem_map_decoder #(.VARIANT(VAR_ROM8K)) u_mem_map_decoder (.I_SYS_CLK(clk),
    .I_SRST(srst), .I_PROCESSOR_MODE_SELECT(strap), .I_PROG_REQ(prq), .I_PROG_WR(pwr),
    .I_PROG_ADDR(pa), .I_DRD_REQ(rrq), .I_DRD_SPACE(rsp), .I_DRD_ADDR(ra),
    .I_DWR_REQ(wrq), .I_DWR_SPACE(wsp), .I_DWR_ADDR(wa), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PROG_TGT(ptgt),
    .O_PROG_EXT(pext), .O_PROG_WAIT(), .O_PROG_OFS(pofs), .O_DRD_TGT(rtgt),
    .O_DRD_EXT(rext), .O_DRD_WAIT(rwait), .O_DRD_OFS(), .O_DWR_TGT(wtgt),
    .O_DWR_EXT(wext), .O_DWR_WAIT(wwait),
    .O_DWR_OFS(), .O_ROM_MAPPED(rom_mapped));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) failures++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb

  task automatic rst(input logic s);
    @(posedge clk);
    strap <= s;
    srst  <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    {mode, ram, block_zero_program_map, sram_data_overlay} = {s, 3'h0};
    @(negedge clk);
    chk(rom_mapped, !s);
  endtask : rst

  // reference map of the second variant
  function automatic logic [3:0] e_prog(input logic [15:0] a);
    if (!mode && a <= V1_ROM_TOP) return TGT_ROM;
    if (ram && a >= V1_PSA_LO && a <= V1_PSA_HI) return TGT_SINGLE_ACCESS_RAM;
    if (block_zero_program_map && a >= PB0_LO) return TGT_B0;
    return TGT_EXT;
  endfunction : e_prog

  function automatic logic [3:0] e_data(input logic [1:0] s, input logic [15:0] a);
    if (s == SPACE_GLOBAL) return (a < GLOBAL_LO) ? TGT_RSVD : TGT_EXT;
    if (s == SPACE_IO || a > V1_DSA_HI) return TGT_EXT;
    if (a <= MMR_HI) return TGT_MMR;
    if (a <= B2_HI) return TGT_B2;
    if (a >= DB0_LO && a <= DB0_HI) return block_zero_program_map ? TGT_RSVD : TGT_B0;
    if (a >= B1_LO && a <= B1_HI) return TGT_B1;
    if (a < DSA_LO) return TGT_RSVD;
    return sram_data_overlay ? TGT_SINGLE_ACCESS_RAM : TGT_EXT;
  endfunction : e_data

  // addresses biased toward block boundaries
  function automatic logic [15:0] rnd_addr;
    logic [31:0] r;
    r = $urandom;
    case (r[1:0])
      2'h0: return r[31:16];
      2'h1: return {4'h0, r[27:16]};
      2'h2: return {8'hFE, r[23:16]};
      default: return 16'h1E00 + {6'h00, r[25:16]};
    endcase
  endfunction : rnd_addr

  task automatic txn(input logic [15:0] p);
    logic [3:0] ep, er, ew;
    logic wr, ww;
    logic [1:0] rs, ws;
    logic [15:0] a, b;
    rs = 2'($urandom_range(1, 3));
    ws = 2'($urandom_range(1, 3));
    a = rnd_addr();
    b = rnd_addr();
    u_cpu_bus_model.put(p, rs, a, ws, b);
    ep = e_prog(p);
    er = e_data(rs, a);
    ew = e_data(ws, b);
    wr = (er == TGT_SINGLE_ACCESS_RAM && ep == TGT_SINGLE_ACCESS_RAM);
    ww = (ew == TGT_SINGLE_ACCESS_RAM && (ep == TGT_SINGLE_ACCESS_RAM || er == TGT_SINGLE_ACCESS_RAM));
    @(posedge clk);
    @(negedge clk);
    chk(ptgt, ep);
    chk(pext, ep == TGT_EXT);
    chk(rext, er == TGT_EXT);
    chk(wext, ew == TGT_EXT);
    if (ep == TGT_EXT || ep == TGT_ROM) chk(pofs, p);
    chk(rwait, wr);
    if (!wr) chk(rtgt, er);
    chk(wwait, ww);
    if (!ww) chk(wtgt, ew);
  endtask : txn

  initial begin
    #(25 * 8000);
    failures++;
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    srst = 1'b1;
    strap = 1'b1;
    failures = 0;
    total_checks = 0;
    void'($urandom(7));
    rst(1'b1);
    @(posedge clk);
    strap <= 1'b0;
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0005);
    apb(1'b1, 12'h008, $urandom);
    chk(e, 1'b1);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk({e, q}, 33'h1_0000_0000);
    txn(16'h0000);
    chk(rom_mapped, 1'b0);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, CFG_OFS, 32'(c));
      {sram_data_overlay, block_zero_program_map, ram, mode} = 4'(c);
      apb(1'b0, CFG_OFS, 32'h0000_0000);
      chk(q, 32'(c));
      repeat (30) txn(rnd_addr());
    end
    u_cpu_bus_model.idle();
    @(posedge clk);
    @(negedge clk);
    chk(ptgt, TGT_NONE);
    rst(1'b0);
    txn(16'h0000);
    repeat (20) txn(rnd_addr());
    print_verdict();
  end
endmodule : mem_map_decoder_tb
